// [hw/crd_pkg.sv]
// crd_pkg: register map, descriptor layout and counts for the chained rx dma
// assumes: apb byte addressing, 16-bit memory data bus, 24-bit memory addresses
package crd_pkg;
   // apb byte addresses
   localparam logic [7:0] CRD_MODE_ADDR   = 8'h00;
   localparam logic [7:0] CRD_STAT_ADDR   = 8'h04;
   localparam logic [7:0] CRD_BASE_ADDR   = 8'h08;
   localparam logic [7:0] CRD_END_ADDR    = 8'h0c;
   localparam logic [7:0] CRD_CUR_ADDR    = 8'h10;
   localparam logic [7:0] CRD_BFL_ADDR    = 8'h14;
   localparam logic [7:0] CRD_BAR_ADDR    = 8'h18;
   localparam logic [7:0] CRD_BCR_ADDR    = 8'h1c;
   localparam logic [7:0] CRD_IRQ_ADDR    = 8'h20;
   localparam logic [7:0] CRD_MASK_ADDR   = 8'h24;
   // field positions
   localparam int         CRD_MULTI_BIT   = 0;
   localparam int         CRD_BUSY_BIT    = 0;
   localparam int         CRD_ENABLE_BIT  = 1;
   localparam int         CRD_FEND_BIT    = 0;
   localparam int         CRD_CSTOP_BIT   = 1;
   localparam int         CRD_NIRQ        = 2;
   // descriptor field byte offsets
   localparam logic [23:0] CRD_LINK_OFS   = 24'h000000;
   localparam logic [23:0] CRD_BPL_OFS    = 24'h000002;
   localparam logic [23:0] CRD_BPH_OFS    = 24'h000004;
   localparam logic [23:0] CRD_LEN_OFS    = 24'h000006;
   localparam logic [23:0] CRD_STAT_OFS   = 24'h000008;
   // reset values
   localparam logic [15:0] CRD_RST16      = 16'h0000;
   localparam logic [23:0] CRD_RST24      = 24'h000000;
   localparam logic [7:0]  CRD_RST8       = 8'h00;
   // step sizes
   localparam logic [15:0] CRD_STEP_BYTE  = 16'h0001;
   localparam logic [15:0] CRD_STEP_WORD  = 16'h0002;
   typedef enum logic [2:0] {
      CRD_S_IDLE, CRD_S_RD_LINK, CRD_S_RD_BPL, CRD_S_RD_BPH,
      CRD_S_WR_DATA, CRD_S_WR_LEN, CRD_S_WR_STAT
   } crd_state_e;
endpackage

// [hw/crd_irq.sv]
// crd_irq: sticky event flags, mask, single level interrupt
// assumes: events are one-cycle pulses, clear mask is a one-cycle pulse
`timescale 1ns/1ps
module crd_irq
   import crd_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                ce,
   input  wire logic [CRD_NIRQ-1:0] event_set,
   input  wire logic [CRD_NIRQ-1:0] read_clear,
   input  wire logic [CRD_NIRQ-1:0] mask,
   output logic      [CRD_NIRQ-1:0] flags,
   output logic                     irq
);
   logic [CRD_NIRQ-1:0] next_flags;

   // set wins so an event landing on the clearing read is kept
   always_comb begin
      next_flags = (flags & ~read_clear) | event_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
      end else if (ce) begin
         flags <= next_flags;
      end
   end

   assign irq = |(flags & mask);
endmodule

// [hw/crd_chained_rx_dma.sv]
// crd_chained_rx_dma: receive dma walking a descriptor chain in memory
// assumes: apb master, memory slave holding mem_ack one cycle per access,
// serial receiver offering bytes or words with a frame-last marker
`timescale 1ns/1ps
module crd_chained_rx_dma
   import crd_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        rx_bitsync,
   input  wire logic        rx_valid,
   input  wire logic [15:0] rx_data,
   input  wire logic        rx_word,
   input  wire logic        rx_last,
   input  wire logic [7:0]  rx_status,
   output logic             rx_ready,
   output logic             mem_req,
   output logic             mem_we,
   output logic             mem_byte,
   output logic      [23:0] mem_addr,
   output logic      [15:0] mem_wdata,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        mem_ack,
   output logic             irq
);
   crd_state_e    state, next_state;
   logic          multi, next_multi;
   logic [7:0]    base_high, next_base_high;
   logic [15:0]   end_ptr, next_end_ptr;
   logic [15:0]   rx_len, next_rx_len;
   logic [CRD_NIRQ-1:0] mask, next_mask;
   logic [31:0]   next_prdata;
   logic          pslverr_q, next_pslverr;
   logic          enable, next_enable;
   logic [15:0]   cur_ptr, next_cur_ptr;
   logic [23:0]   bar, next_bar;
   logic [15:0]   buffer_bytes_left, next_bcr;
   logic [15:0]   length, next_length;
   logic [15:0]   link, next_link;
   logic [15:0]   bp_lo, next_bp_lo;
   logic          loaded, next_loaded;
   logic [15:0]   data_q, next_data_q;
   logic          word_q, next_word_q;
   logic          last_q, next_last_q;
   logic [7:0]    fstat_q, next_fstat_q;
   logic          next_mem_req, next_mem_we, next_mem_byte;
   logic [23:0]   next_mem_addr;
   logic [15:0]   next_mem_wdata;
   logic [CRD_NIRQ-1:0] ev, rd_clr, flags;
   logic          wr_acc, rd_setup, rd_acc, mapped;
   logic [15:0]   step;
   logic [23:0]   desc;

   assign pready   = ce;
   assign pslverr  = pslverr_q;
   assign wr_acc   = ce & psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign rd_acc   = ce & psel & penable & ~pwrite;
   assign desc     = {base_high, cur_ptr};
   assign step     = word_q ? CRD_STEP_WORD : CRD_STEP_BYTE;
   // no buffer, no enable or wrong receiver mode: receiver is held off
   assign rx_ready = (state == CRD_S_IDLE) & enable & rx_bitsync & loaded;

   always_comb begin
      unique case (paddr)
         CRD_MODE_ADDR, CRD_STAT_ADDR, CRD_BASE_ADDR, CRD_END_ADDR, CRD_CUR_ADDR,
         CRD_BFL_ADDR, CRD_BAR_ADDR, CRD_BCR_ADDR, CRD_IRQ_ADDR,
         CRD_MASK_ADDR: mapped = 1'b1;
         default:       mapped = 1'b0;
      endcase
   end

   // software-only registers and read path
   always_comb begin
      next_multi     = multi;
      next_base_high = base_high;
      next_end_ptr   = end_ptr;
      next_rx_len    = rx_len;
      next_mask      = mask;
      next_prdata    = prdata;
      next_pslverr   = 1'b0;
      rd_clr         = '0;
      if (wr_acc) begin
         unique case (paddr)
            CRD_MODE_ADDR: next_multi     = pwdata[CRD_MULTI_BIT];
            CRD_BASE_ADDR: next_base_high = pwdata[7:0];
            CRD_END_ADDR:  next_end_ptr   = pwdata[15:0];
            CRD_BFL_ADDR:  next_rx_len    = pwdata[15:0];
            CRD_MASK_ADDR: next_mask      = pwdata[CRD_NIRQ-1:0];
            default:       next_mask      = mask;
         endcase
      end
      if (rd_acc && paddr == CRD_IRQ_ADDR) begin
         rd_clr = '1;
      end
      if (psel && !penable) begin
         next_pslverr = ~mapped;
      end
      if (rd_setup) begin
         next_prdata = 32'h00000000;
         unique case (paddr)
            CRD_MODE_ADDR: next_prdata[CRD_MULTI_BIT] = multi;
            CRD_STAT_ADDR: begin
               next_prdata[CRD_ENABLE_BIT] = enable;
               next_prdata[CRD_BUSY_BIT]   = (state != CRD_S_IDLE);
            end
            CRD_BASE_ADDR: next_prdata[7:0]  = base_high;
            CRD_END_ADDR:  next_prdata[15:0] = end_ptr;
            CRD_CUR_ADDR:  next_prdata[15:0] = cur_ptr;
            CRD_BFL_ADDR:  next_prdata[15:0] = rx_len;
            CRD_BAR_ADDR:  next_prdata[23:0] = bar;
            CRD_BCR_ADDR:  next_prdata[15:0] = buffer_bytes_left;
            CRD_IRQ_ADDR:  next_prdata[CRD_NIRQ-1:0] = flags;
            CRD_MASK_ADDR: next_prdata[CRD_NIRQ-1:0] = mask;
            default:       next_prdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         multi     <= 1'b0;
         base_high <= CRD_RST8;
         end_ptr   <= CRD_RST16;
         rx_len    <= CRD_RST16;
         mask      <= '0;
         prdata    <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (ce) begin
         multi     <= next_multi;
         base_high <= next_base_high;
         end_ptr   <= next_end_ptr;
         rx_len    <= next_rx_len;
         mask      <= next_mask;
         prdata    <= next_prdata;
         pslverr_q <= next_pslverr;
      end
   end

   // channel state machine and counters
   always_comb begin
      next_state   = state;
      next_enable  = enable;
      next_cur_ptr = cur_ptr;
      next_bar     = bar;
      next_bcr     = buffer_bytes_left;
      next_length  = length;
      next_link    = link;
      next_bp_lo   = bp_lo;
      next_loaded  = loaded;
      next_data_q  = data_q;
      next_word_q  = word_q;
      next_last_q  = last_q;
      next_fstat_q = fstat_q;
      ev           = '0;
      // buffer address and count are read-only: only the channel moves them; the descriptor pointer also takes apb writes
      if (wr_acc && paddr == CRD_CUR_ADDR) begin
         next_cur_ptr = pwdata[15:0];
      end
      if (wr_acc && paddr == CRD_STAT_ADDR) begin
         next_enable = pwdata[CRD_ENABLE_BIT];
      end
      unique case (state)
         CRD_S_IDLE: begin
            if (enable && rx_bitsync && rx_valid) begin
               if (loaded) begin
                  next_data_q  = rx_data;
                  next_word_q  = rx_word;
                  next_last_q  = rx_last;
                  next_fstat_q = rx_status;
                  next_state   = CRD_S_WR_DATA;
               end else if (cur_ptr == end_ptr) begin
                  next_enable        = 1'b0;
                  ev[CRD_CSTOP_BIT]  = 1'b1;
               end else begin
                  next_state = CRD_S_RD_LINK;
               end
            end
         end
         CRD_S_RD_LINK: if (mem_ack) begin
            next_link  = mem_rdata;
            next_state = CRD_S_RD_BPL;
         end
         CRD_S_RD_BPL: if (mem_ack) begin
            next_bp_lo = mem_rdata;
            next_state = CRD_S_RD_BPH;
         end
         CRD_S_RD_BPH: if (mem_ack) begin
            next_bar    = {mem_rdata[7:0], bp_lo};
            next_bcr    = rx_len;
            next_length = CRD_RST16;
            next_loaded = 1'b1;
            next_state  = CRD_S_IDLE;
         end
         CRD_S_WR_DATA: if (mem_ack) begin
            next_bar    = bar + {8'h00, step};
            next_bcr    = buffer_bytes_left - step;
            next_length = length + step;
            // a full buffer or a frame end both close the descriptor
            if (last_q || buffer_bytes_left == step) begin
               next_state = CRD_S_WR_LEN;
            end else begin
               next_state = CRD_S_IDLE;
            end
         end
         CRD_S_WR_LEN: if (mem_ack) begin
            if (last_q) begin
               next_state = CRD_S_WR_STAT;
            end else begin
               next_cur_ptr = link;
               next_loaded  = 1'b0;
               next_state   = CRD_S_IDLE;
            end
         end
         CRD_S_WR_STAT: if (mem_ack) begin
            next_cur_ptr     = link;
            next_loaded      = 1'b0;
            ev[CRD_FEND_BIT] = 1'b1;
            next_state       = CRD_S_IDLE;
            if (!multi) begin
               next_enable = 1'b0;
            end
         end
      endcase
      // outgoing memory request follows the state being entered
      next_mem_req   = (next_state != CRD_S_IDLE);
      next_mem_we    = 1'b0;
      next_mem_byte  = 1'b0;
      next_mem_addr  = mem_addr;
      next_mem_wdata = mem_wdata;
      unique case (next_state)
         CRD_S_IDLE:    next_mem_addr = mem_addr;
         CRD_S_RD_LINK: next_mem_addr = {base_high, next_cur_ptr} + CRD_LINK_OFS;
         CRD_S_RD_BPL:  next_mem_addr = desc + CRD_BPL_OFS;
         CRD_S_RD_BPH:  next_mem_addr = desc + CRD_BPH_OFS;
         CRD_S_WR_DATA: begin
            next_mem_we    = 1'b1;
            next_mem_byte  = ~next_word_q;
            next_mem_addr  = next_bar;
            next_mem_wdata = next_data_q;
         end
         CRD_S_WR_LEN: begin
            next_mem_we    = 1'b1;
            next_mem_addr  = desc + CRD_LEN_OFS;
            next_mem_wdata = next_length;
         end
         CRD_S_WR_STAT: begin
            next_mem_we    = 1'b1;
            next_mem_addr  = desc + CRD_STAT_OFS;
            next_mem_wdata = {8'h00, fstat_q};
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= CRD_S_IDLE;
         enable    <= 1'b0;
         cur_ptr   <= CRD_RST16;
         bar       <= CRD_RST24;
         buffer_bytes_left       <= CRD_RST16;
         length    <= CRD_RST16;
         link      <= CRD_RST16;
         bp_lo     <= CRD_RST16;
         loaded    <= 1'b0;
         data_q    <= CRD_RST16;
         word_q    <= 1'b0;
         last_q    <= 1'b0;
         fstat_q   <= CRD_RST8;
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_byte  <= 1'b0;
         mem_addr  <= CRD_RST24;
         mem_wdata <= CRD_RST16;
      end else if (ce) begin
         state     <= next_state;
         enable    <= next_enable;
         cur_ptr   <= next_cur_ptr;
         bar       <= next_bar;
         buffer_bytes_left       <= next_bcr;
         length    <= next_length;
         link      <= next_link;
         bp_lo     <= next_bp_lo;
         loaded    <= next_loaded;
         data_q    <= next_data_q;
         word_q    <= next_word_q;
         last_q    <= next_last_q;
         fstat_q   <= next_fstat_q;
         mem_req   <= next_mem_req;
         mem_we    <= next_mem_we;
         mem_byte  <= next_mem_byte;
         mem_addr  <= next_mem_addr;
         mem_wdata <= next_mem_wdata;
      end
   end

   crd_irq u_irq (
      .pclk       (pclk),
      .presetn    (presetn),
      .ce         (ce),
      .event_set  (ev),
      .read_clear (rd_clr),
      .mask       (mask),
      .flags      (flags),
      .irq        (irq)
   );

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_desc_addr: assert property (state == CRD_S_RD_LINK && mem_req |->
      mem_addr == {base_high, cur_ptr})
      else $error("descriptor read address wrong");
   a_buf_load: assert property (ce && state == CRD_S_RD_BPH && mem_ack |=>
      bar == {$past(mem_rdata[7:0]), $past(bp_lo)} && buffer_bytes_left == $past(rx_len) && loaded)
      else $error("buffer address or count not loaded");
   a_count_step: assert property (ce && state == CRD_S_WR_DATA && mem_ack |=>
      bar == $past(bar) + {8'h00, $past(step)} && buffer_bytes_left == $past(buffer_bytes_left) - $past(step))
      else $error("address or count step wrong");
   a_zero_close: assert property (ce && state == CRD_S_WR_DATA && mem_ack
      && buffer_bytes_left == step |=> state == CRD_S_WR_LEN)
      else $error("full buffer not closed");
   a_status_write: assert property (state == CRD_S_WR_STAT && mem_req |->
      mem_we && mem_wdata == {8'h00, fstat_q} && mem_addr == desc + CRD_STAT_OFS)
      else $error("frame status write wrong");
   a_single_stop: assert property (ce && state == CRD_S_WR_STAT && mem_ack
      && !multi && !(wr_acc && paddr == CRD_STAT_ADDR) |=> !enable && !loaded
      && cur_ptr == $past(link))
      else $error("single frame did not stop");
   a_frame_flag: assert property (ce && state == CRD_S_WR_STAT && mem_ack |=>
      flags[CRD_FEND_BIT])
      else $error("frame end flag missing");
   a_chain_stop: assert property (ce && state == CRD_S_IDLE && enable && rx_bitsync
      && rx_valid && !loaded && cur_ptr == end_ptr && !wr_acc |=> !enable
      && flags[CRD_CSTOP_BIT] && state == CRD_S_IDLE)
      else $error("chain stop not taken");
   a_sync_only: assert property (!rx_bitsync |-> !rx_ready)
      else $error("receiver accepted outside bit-sync mode");
endmodule

// [verification/crd_mem_model.sv]
// crd_mem_model: behavioural 16-bit system memory behind the rx dma
// assumes: one request at a time, ack is a one-cycle pulse, byte data in [7:0]
`timescale 1ns/1ps
module crd_mem_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic        mem_byte,
   input  wire logic [23:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic      [15:0] mem_rdata,
   output logic             mem_ack
);
   logic [7:0] mem [logic [23:0]];
   logic [2:0] cnt;
   // idle data bus toggles so a stale value never passes as a read
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         mem_rdata <= 16'h5a5a;
         cnt <= 3'h0;
      end else if (mem_ack) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end else if (mem_req && (!slow || cnt == 3'h3)) begin
         cnt <= 3'h0;
         mem_ack <= 1'b1;
         if (mem_we) begin
            mem[mem_addr] = mem_wdata[7:0];
            if (!mem_byte) mem[mem_addr + 24'h1] = mem_wdata[15:8];
         end else begin
            mem_rdata <= {mem[mem_addr + 24'h1], mem[mem_addr]};
         end
      end else begin
         cnt <= mem_req ? cnt + 3'h1 : 3'h0;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// [verification/crd_chained_rx_dma_tb.sv]
// crd_chained_rx_dma_tb: self-checking bench for the chained rx dma
// assumes: crd_pkg register map, crd_mem_model as system memory
`timescale 1ns/1ps
module crd_chained_rx_dma_tb;
   import crd_pkg::*;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, slow;
   logic        rx_bitsync, rx_valid, rx_word, rx_last, rx_ready, irq;
   logic        mem_req, mem_we, mem_byte, mem_ack;
   logic [7:0]  paddr, rx_status;
   logic [15:0] rx_data, mem_wdata, mem_rdata;
   logic [23:0] mem_addr;
   logic [31:0] pwdata, prdata, rd;
   logic        err, tk;
   int          n_fail, samples_checked;

   crd_chained_rx_dma i_crd_chained_rx_dma (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_bitsync(rx_bitsync),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_word(rx_word), .rx_last(rx_last),
      .rx_status(rx_status), .rx_ready(rx_ready), .mem_req(mem_req), .mem_we(mem_we),
      .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));
   crd_mem_model i_mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
      .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata), .mem_ack(mem_ack));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic finish_test;
      if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // request held until pready is seen high at a rising edge; only the watchdog ends a wait
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] d, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, err);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, rd, err);
      chk(rd, exp);
   endtask

   task automatic chki(input logic exp);
      @(negedge pclk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask

   task automatic chkm(input logic [23:0] a, input logic [7:0] exp);
      chk({24'h0, i_mem.mem[a]}, {24'h0, exp});
   endtask

   task automatic desc(input logic [15:0] p, input logic [15:0] link, input logic [23:0] bp);
      logic [23:0] b;
      b = {8'h12, p};
      i_mem.mem[b] = link[7:0];
      i_mem.mem[b + 24'h1] = link[15:8];
      i_mem.mem[b + 24'h2] = bp[7:0];
      i_mem.mem[b + 24'h3] = bp[15:8];
      i_mem.mem[b + 24'h4] = bp[23:16];
      i_mem.mem[b + 24'h5] = 8'h00;
      for (int i = 6; i < 10; i++) i_mem.mem[b + 24'(i)] = 8'hee;
   endtask

   // released data shows its inverse, never the last value
   task automatic offer(input logic [15:0] d, input logic w, input logic l,
                        input logic [7:0] s);
      tk = 1'b0;
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_data <= d;
      rx_word <= w;
      rx_last <= l;
      rx_status <= s;
      for (int i = 0; i < 40 && !tk; i++) begin
         @(posedge pclk);
         tk = rx_ready;
      end
      rx_valid <= 1'b0;
      rx_data <= ~d;
   endtask

   task automatic put(input logic [15:0] d, input logic w, input logic l,
                      input logic [7:0] s);
      logic [31:0] q;
      logic e;
      offer(d, w, l, s);
      chk({31'h0, tk}, 32'h1);
      for (int i = 0; i < 30; i++) begin
         apb(1'b0, CRD_STAT_ADDR, 32'h0, q, e);
         if (q[CRD_BUSY_BIT] === 1'b0) break;
      end
      chk({31'h0, q[CRD_BUSY_BIT]}, 32'h0);
   endtask

   task automatic test_multi;
      desc(16'h0100, 16'h0110, 24'h120400);
      desc(16'h0110, 16'h0120, 24'h120500);
      desc(16'h0120, 16'h0100, 24'h120600);
      wr(CRD_BASE_ADDR, 32'h12);
      wr(CRD_END_ADDR, 32'h0120);
      wr(CRD_CUR_ADDR, 32'h0100);
      wr(CRD_BFL_ADDR, 32'h4);
      wr(CRD_MODE_ADDR, 32'h1);
      wr(CRD_MASK_ADDR, 32'h3);
      wr(CRD_STAT_ADDR, 32'h2);
      rdc(CRD_STAT_ADDR, 32'h2);
      slow <= 1'b1;
      put(16'h00a1, 1'b0, 1'b0, 8'h00);
      rdc(CRD_BAR_ADDR, 32'h120401);
      rdc(CRD_BCR_ADDR, 32'h3);
      put(16'hc3b2, 1'b1, 1'b0, 8'h00);
      rdc(CRD_BAR_ADDR, 32'h120403);
      rdc(CRD_BCR_ADDR, 32'h1);
      put(16'h00d4, 1'b0, 1'b0, 8'h00);
      chkm(24'h120400, 8'ha1);
      chkm(24'h120401, 8'hb2);
      chkm(24'h120402, 8'hc3);
      chkm(24'h120403, 8'hd4);
      chkm(24'h120106, 8'h04);
      chkm(24'h120108, 8'hee);
      rdc(CRD_CUR_ADDR, 32'h0110);
      slow <= 1'b0;
      put(16'h7e55, 1'b1, 1'b1, 8'h5a);
      chkm(24'h120500, 8'h55);
      chkm(24'h120501, 8'h7e);
      chkm(24'h120116, 8'h02);
      chkm(24'h120118, 8'h5a);
      chkm(24'h120119, 8'h00);
      rdc(CRD_CUR_ADDR, 32'h0120);
      rdc(CRD_STAT_ADDR, 32'h2);
      chki(1'b1);
      rdc(CRD_IRQ_ADDR, 32'h1);
      chki(1'b0);
   endtask

   task automatic test_stop;
      offer(16'h0011, 1'b0, 1'b0, 8'h00);
      chk({31'h0, tk}, 32'h0);
      rdc(CRD_STAT_ADDR, 32'h0);
      chki(1'b1);
      rdc(CRD_IRQ_ADDR, 32'h2);
      rdc(CRD_CUR_ADDR, 32'h0120);
   endtask

   task automatic test_single;
      wr(CRD_END_ADDR, 32'h0100);
      wr(CRD_MODE_ADDR, 32'h0);
      wr(CRD_MASK_ADDR, 32'h2);
      wr(CRD_STAT_ADDR, 32'h2);
      rx_bitsync <= 1'b0;
      offer(16'h0022, 1'b0, 1'b1, 8'h00);
      chk({31'h0, tk}, 32'h0);
      rx_bitsync <= 1'b1;
      put(16'h00e7, 1'b0, 1'b1, 8'h33);
      chkm(24'h120600, 8'he7);
      chkm(24'h120126, 8'h01);
      chkm(24'h120128, 8'h33);
      rdc(CRD_STAT_ADDR, 32'h0);
      rdc(CRD_CUR_ADDR, 32'h0100);
      chki(1'b0);
      rdc(CRD_IRQ_ADDR, 32'h1);
      // restart after a finished single frame, end pointer moved while enabled
      wr(CRD_STAT_ADDR, 32'h2);
      wr(CRD_END_ADDR, 32'h0110);
      put(16'h0099, 1'b0, 1'b1, 8'h44);
      chkm(24'h120400, 8'h99);
      chkm(24'h120108, 8'h44);
      rdc(CRD_STAT_ADDR, 32'h0);
      rdc(CRD_CUR_ADDR, 32'h0110);
   endtask

   initial begin
      n_fail = 0;
      samples_checked = 0;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slow = 1'b0;
      rx_bitsync = 1'b1;
      rx_valid = 1'b0;
      rx_data = 16'h0;
      rx_word = 1'b0;
      rx_last = 1'b0;
      rx_status = 8'h00;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc(CRD_STAT_ADDR, 32'h0);
      rdc(CRD_CUR_ADDR, 32'h0);
      apb(1'b0, 8'hfc, 32'h0, rd, err);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      test_multi();
      test_stop();
      test_single();
      finish_test();
   end

   // a hang in an apb handshake ends here; rx offers and busy polls give up on their own
   initial begin
      #200000;
      n_fail++;
      finish_test();
   end
endmodule
